// File: core/mcubd_pkg.sv
// Overview of operation
// - bit ops by top nibble, fields b/a/f
// - 1110_0ccc conditional branch, two cycles taken
// - call is two words, s selects fast save
// - absolute jump two words, 20-bit target
// - lone 1111 word executes as no-operation
// - fixed words: nop, watchdog, push, pop, adjust
// - standby word and software reset word
// - interrupt return re-enables the irq enable only, not all
// - plain and literal return, two cycles
// - literal add, subtract, multiply encodings
// - literal and, or, xor update z, n
// - literal move, one cycle, no flags
// - bank select load of four-bit literal
// - pointer load, two words, 12-bit value
// - table read with four pointer modes
// - table write with four pointer modes
// - port modify reads live pin levels
// - bit op on timer zero clears prescaler
// - pc change or true test costs extra cycle
package mcubd_pkg;

	// ========================================
	// opcode fields
	localparam logic [3:0] NIB_BIT_SET  = 4'h8;
	localparam logic [3:0] NIB_BIT_CLR  = 4'h9;
	localparam logic [3:0] NIB_BIT_TGL  = 4'h7;
	localparam logic [3:0] NIB_SKIP_SET = 4'ha;
	localparam logic [3:0] NIB_SKIP_CLR = 4'hb;
	localparam logic [3:0] NIB_CTRL     = 4'he;
	localparam logic [3:0] NIB_WORD2    = 4'hf;
	localparam logic [7:0] HB_ADDL      = 8'h0f;
	localparam logic [7:0] HB_SUBL      = 8'h08;
	localparam logic [7:0] HB_MULL      = 8'h0d;
	localparam logic [7:0] HB_ANDL      = 8'h0b;
	localparam logic [7:0] HB_IORL      = 8'h09;
	localparam logic [7:0] HB_XORL      = 8'h0a;
	localparam logic [7:0] HB_MOVL      = 8'h0e;
	localparam logic [7:0] HB_RETL      = 8'h0c;
	localparam logic [7:0] HB_BANK      = 8'h01;
	localparam logic [7:0] HB_FIXED     = 8'h00;
	localparam logic [7:0] LB_NOP       = 8'h00;
	localparam logic [7:0] LB_SLEEP     = 8'h03;
	localparam logic [7:0] LB_WDT       = 8'h04;
	localparam logic [7:0] LB_PUSH      = 8'h05;
	localparam logic [7:0] LB_POP       = 8'h06;
	localparam logic [7:0] LB_DADJ      = 8'h07;
	localparam logic [7:0] LB_RESET     = 8'hff;
	localparam logic [6:0] LB_IRET      = 7'h08;
	localparam logic [6:0] LB_RETURN    = 7'h09;
	localparam logic [5:0] LB_TRD       = 6'h02;
	localparam logic [5:0] LB_TWR       = 6'h03;

	// ========================================
	// file addresses seen by the decoder (access bank)
	localparam logic [7:0] PORT_FIRST = 8'h80;
	localparam logic [7:0] PORT_LAST  = 8'h87;
	localparam logic [7:0] TMRZ_ADDR  = 8'hd0;

	// ========================================
	// register map and reset values
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_LAST   = 12'h008;
	localparam logic [11:0] REG_COUNT  = 12'h00c;
	localparam logic        CTRL_RST   = 1'b1;

	typedef enum logic [2:0] {
		ST_EXEC  = 3'b001,
		ST_WORD2 = 3'b010,
		ST_FLUSH = 3'b100
	} mcubd_state_t;

	typedef enum logic [4:0] {
		no_operation_op, bit_clear_op, bit_set_op, bit_toggle_op,
		skip_if_bit_clear_op, skip_if_bit_set_op, cond_branch_op,
		call_op, goto_op, watchdog_clear_op, push_op, pop_op,
		decimal_adjust_op, standby_op, soft_reset_op,
		interrupt_return_op, return_op, literal_return_op,
		literal_add_op, literal_subtract_op, literal_multiply_op,
		literal_and_op, literal_or_op, literal_xor_op, literal_move_op,
		bank_select_load_op, pointer_load_op, table_read_op,
		table_write_op, other_op
	} mcubd_op_t;

	typedef struct packed {
		logic c;
		logic dc;
		logic z;
		logic ov;
		logic n;
		logic tmo_pwr;
		logic irq;
		logic all;
	} mcubd_flags_t;

	typedef struct packed {
		logic c;
		logic z;
		logic ov;
		logic n;
	} mcubd_alu_t;

	typedef struct packed {
		mcubd_op_t    op;
		logic [15:0]  word;
		logic [2:0]   bit_num;
		logic         bank_a;
		logic [7:0]   file_addr;
		logic [7:0]   literal;
		logic         fast;
		logic         taken;
		logic [19:0]  target;
		logic [1:0]   ptr_sel;
		logic [11:0]  ptr_val;
		logic [1:0]   tbl_mode;
		logic [1:0]   cycles;
		logic         read_pins;
		logic         presc_clr;
		mcubd_flags_t flags;
	} mcubd_dec_t;

endpackage : mcubd_pkg

// File: core/mcubd_core.sv
`timescale 1ns/1ps
module mcubd_core (
	input  wire logic                  pclk,          // core instruction clock
	input  wire logic                  presetn,       // async reset, active low
	input  wire logic                  ce,            // clock enable, freezes all state
	input  wire logic                  psel,          // apb select
	input  wire logic                  penable,       // apb access phase
	input  wire logic                  pwrite,        // apb write
	input  wire logic [11:0]           paddr,         // apb byte address
	input  wire logic [31:0]           pwdata,        // apb write data
	output logic      [31:0]           prdata,        // apb read data
	output logic                       pready,        // apb ready
	output logic                       pslverr,       // apb error, unmapped
	input  wire logic                  fetch_valid,   // fetch_word present
	input  wire logic [15:0]           fetch_word,    // fetched program word
	input  wire logic [19:0]           pc_inc,        // incremented pc, words
	input  wire mcubd_pkg::mcubd_alu_t alu_flags,     // live status flags
	input  wire logic                  file_bit,      // addressed bit value
	input  wire logic                  presc_assigned,// prescaler on timer zero
	output mcubd_pkg::mcubd_dec_t      dec_q,         // decoded instruction
	output logic                       dec_valid_q    // dec_q new this cycle
);
	import mcubd_pkg::*;

	// ========================================
	// state and registers
	mcubd_state_t state_q;
	mcubd_dec_t   held_q;
	mcubd_dec_t   dn;
	logic         ctrl_en_q;
	logic [15:0]  last_q;
	logic [31:0]  count_q;
	logic [31:0]  prdata_q;
	logic         two_word;
	logic         flush;
	logic         taken_c;
	logic         port_hit;
	logic         tmr_hit;
	logic         acc;
	logic         take;
	logic         wr;
	logic         hit;
	logic [15:0]  w;
	logic [11:0]  word2_hi;

	assign w        = fetch_word;
	assign word2_hi = fetch_word[11:0];
	assign take     = ce && fetch_valid;
	assign acc      = take && state_q == ST_EXEC && ctrl_en_q;
	assign port_hit = !w[8] && w[7:0] >= PORT_FIRST && w[7:0] <= PORT_LAST;
	assign tmr_hit  = !w[8] && w[7:0] == TMRZ_ADDR && presc_assigned;

	always_comb begin
		case (w[10:8])
			3'd0: taken_c = alu_flags.z;
			3'd1: taken_c = !alu_flags.z;
			3'd2: taken_c = alu_flags.c;
			3'd3: taken_c = !alu_flags.c;
			3'd4: taken_c = alu_flags.ov;
			3'd5: taken_c = !alu_flags.ov;
			3'd6: taken_c = alu_flags.n;
			default: taken_c = !alu_flags.n;
		endcase
	end

	// ========================================
	// decode
	always_comb begin
		dn          = '0;
		dn.op       = no_operation_op;
		dn.word     = w;
		dn.cycles   = 2'd1;
		dn.bit_num  = w[11:9];
		dn.bank_a   = w[8];
		dn.file_addr = w[7:0];
		dn.literal  = w[7:0];
		two_word    = 1'b0;
		flush       = 1'b0;
		case (state_q)
			ST_WORD2: begin
				dn = held_q;
				dn.word = w;
				// the second word is used whatever its top nibble holds
				if (held_q.op == pointer_load_op) begin
					dn.ptr_val = {held_q.ptr_val[11:8], w[7:0]};
				end else begin
					dn.target = {w[11:0], held_q.target[7:0]};
				end
			end
			ST_FLUSH: begin
				dn.op = no_operation_op;
			end
			default: begin
				if (!ctrl_en_q) begin
					dn.op = no_operation_op;
				end else begin
					case (w[15:12])
						NIB_BIT_CLR: begin
							dn.op = bit_clear_op;
							dn.read_pins = port_hit;
							dn.presc_clr = tmr_hit;
						end
						NIB_BIT_SET: begin
							dn.op = bit_set_op;
							dn.read_pins = port_hit;
							dn.presc_clr = tmr_hit;
						end
						NIB_BIT_TGL: begin
							dn.op = bit_toggle_op;
							dn.read_pins = port_hit;
							dn.presc_clr = tmr_hit;
						end
						NIB_SKIP_CLR: begin
							dn.op = skip_if_bit_clear_op;
							flush = !file_bit;
						end
						NIB_SKIP_SET: begin
							dn.op = skip_if_bit_set_op;
							flush = file_bit;
						end
						NIB_CTRL: begin
							if (!w[11]) begin
								dn.op = cond_branch_op;
								dn.taken = taken_c;
								dn.target = pc_inc + {{12{w[7]}}, w[7:0]};
								flush = taken_c;
							end else if (w[11:9] == 3'b110) begin
								dn.op = call_op;
								dn.fast = w[8];
								dn.target = {12'h000, w[7:0]};
								two_word = 1'b1;
							end else if (w[11:8] == 4'hf) begin
								dn.op = goto_op;
								dn.target = {12'h000, w[7:0]};
								two_word = 1'b1;
							end else if (w[11:6] == 6'b1110_00) begin
								dn.op = pointer_load_op;
								dn.ptr_sel = w[5:4];
								dn.ptr_val = {w[3:0], 8'h00};
								two_word = 1'b1;
							end else begin
								dn.op = other_op;
							end
						end
						NIB_WORD2: begin
							dn.op = no_operation_op;
						end
						default: begin
							if (w[15:8] == HB_ADDL) begin
								dn.op = literal_add_op;
								dn.flags = 8'b1111_1000;
							end else if (w[15:8] == HB_SUBL) begin
								dn.op = literal_subtract_op;
								dn.flags = 8'b1111_1000;
							end else if (w[15:8] == HB_MULL) begin
								dn.op = literal_multiply_op;
							end else if (w[15:8] == HB_ANDL) begin
								dn.op = literal_and_op;
								dn.flags = 8'b0010_1000;
							end else if (w[15:8] == HB_IORL) begin
								dn.op = literal_or_op;
								dn.flags = 8'b0010_1000;
							end else if (w[15:8] == HB_XORL) begin
								dn.op = literal_xor_op;
								dn.flags = 8'b0010_1000;
							end else if (w[15:8] == HB_MOVL) begin
								dn.op = literal_move_op;
							end else if (w[15:8] == HB_RETL) begin
								dn.op = literal_return_op;
								flush = 1'b1;
							end else if (w[15:8] == HB_BANK && w[7:4] == 4'h0) begin
								dn.op = bank_select_load_op;
								dn.literal = {4'h0, w[3:0]};
							end else if (w[15:8] == HB_FIXED) begin
								if (w[7:0] == LB_NOP) begin
									dn.op = no_operation_op;
								end else if (w[7:0] == LB_WDT) begin
									dn.op = watchdog_clear_op;
									dn.flags.tmo_pwr = 1'b1;
								end else if (w[7:0] == LB_PUSH) begin
									dn.op = push_op;
								end else if (w[7:0] == LB_POP) begin
									dn.op = pop_op;
								end else if (w[7:0] == LB_DADJ) begin
									dn.op = decimal_adjust_op;
									dn.flags.c = 1'b1;
								end else if (w[7:0] == LB_SLEEP) begin
									dn.op = standby_op;
									dn.flags.tmo_pwr = 1'b1;
								end else if (w[7:0] == LB_RESET) begin
									dn.op = soft_reset_op;
									dn.flags = 8'hff;
								end else if (w[7:1] == LB_IRET) begin
									dn.op = interrupt_return_op;
									dn.fast = w[0];
									dn.flags.irq = 1'b1;
									flush = 1'b1;
								end else if (w[7:1] == LB_RETURN) begin
									dn.op = return_op;
									dn.fast = w[0];
									flush = 1'b1;
								end else if (w[7:2] == LB_TRD) begin
									dn.op = table_read_op;
									dn.tbl_mode = w[1:0];
									flush = 1'b1;
								end else if (w[7:2] == LB_TWR) begin
									dn.op = table_write_op;
									dn.tbl_mode = w[1:0];
									flush = 1'b1;
								end else begin
									dn.op = other_op;
								end
							end else begin
								// byte-oriented words pass through for the file decoder
								dn.op = other_op;
							end
						end
					endcase
					if (two_word || flush) begin
						dn.cycles = 2'd2;
					end
				end
			end
		endcase
	end

	// ========================================
	// sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_EXEC;
		end else if (take) begin
			case (state_q)
				ST_EXEC: begin
					if (two_word) begin
						state_q <= ST_WORD2;
					end else if (flush) begin
						state_q <= ST_FLUSH;
					end else begin
						state_q <= ST_EXEC;
					end
				end
				default: begin
					state_q <= ST_EXEC;
				end
			endcase
		end
	end

	// first word of a pair is held back, nothing issues until the pair is whole
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_q <= '0;
		end else if (take && state_q == ST_EXEC && two_word) begin
			held_q <= dn;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_q       <= '0;
			dec_valid_q <= 1'b0;
		end else if (ce) begin
			dec_valid_q <= take && !(state_q == ST_EXEC && two_word);
			if (take && !(state_q == ST_EXEC && two_word)) begin
				dec_q <= dn;
			end
		end
	end

	// ========================================
	// apb slave, zero wait while ce is high
	assign pready  = ce;
	assign hit     = paddr == REG_CTRL || paddr == REG_STATUS ||
	                 paddr == REG_LAST || paddr == REG_COUNT;
	assign pslverr = psel && penable && !hit;
	assign wr      = ce && psel && penable && pwrite;
	assign prdata  = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_q <= CTRL_RST;
		end else if (wr && paddr == REG_CTRL) begin
			ctrl_en_q <= pwdata[0];
		end
	end

	// a write to the count register clears it; the clear beats a retire
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 32'h0;
		end else if (wr && paddr == REG_COUNT) begin
			count_q <= 32'h0;
		end else if (ce && dec_valid_q) begin
			count_q <= count_q + 32'h1;
		end
	end

	// the last word is kept even when a count clear lands on the same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_q <= 16'h0;
		end else if (ce && dec_valid_q) begin
			last_q <= dec_q.word;
		end
	end

	// read data captured in the setup phase so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (ce && psel && !penable) begin
			if (paddr == REG_CTRL) begin
				prdata_q <= {31'h0, ctrl_en_q};
			end else if (paddr == REG_STATUS) begin
				prdata_q <= {19'h0, state_q, 5'h0, dec_q.op};
			end else if (paddr == REG_LAST) begin
				prdata_q <= {16'h0, last_q};
			end else if (paddr == REG_COUNT) begin
				prdata_q <= count_q;
			end else begin
				prdata_q <= 32'h0;
			end
		end
	end

	// ========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	bit_clear_a: assert property (acc && w[15:12] == NIB_BIT_CLR |=>
		dec_valid_q && dec_q.op == bit_clear_op && dec_q.bit_num == dec_q.word[11:9])
		else $error("bit clear decode wrong");
	branch_taken_a: assert property (acc && w[15:11] == 5'b11100 && taken_c |=>
		state_q == ST_FLUSH && dec_q.cycles == 2'd2)
		else $error("taken branch did not flush");
	branch_target_a: assert property (acc && w[15:11] == 5'b11100 |=>
		dec_q.target == $past(pc_inc) + {{12{dec_q.word[7]}}, dec_q.word[7:0]})
		else $error("branch target wrong");
	call_hold_a: assert property (acc && w[15:9] == 7'b1110110 |=>
		state_q == ST_WORD2 && !dec_valid_q && held_q.fast == $past(w[8]))
		else $error("call first word not held");
	word2_join_a: assert property (take && state_q == ST_WORD2 &&
		held_q.op != pointer_load_op |=>
		dec_valid_q && dec_q.target[19:8] == $past(word2_hi))
		else $error("jump target not joined");
	lone_word2_a: assert property (acc && w[15:12] == NIB_WORD2 |=>
		dec_q.op == no_operation_op && state_q == ST_EXEC)
		else $error("lone second word not a nop");
	wdt_flags_a: assert property (acc && w == {HB_FIXED, LB_WDT} |=>
		dec_q.op == watchdog_clear_op && dec_q.flags.tmo_pwr && dec_q.cycles == 2'd1)
		else $error("watchdog clear decode wrong");
	standby_a: assert property (acc && w == {HB_FIXED, LB_SLEEP} |=>
		dec_q.op == standby_op && dec_q.flags.tmo_pwr && state_q == ST_EXEC)
		else $error("standby decode wrong");
	irq_return_a: assert property (acc && w[15:1] == {HB_FIXED, LB_IRET} |=>
		dec_q.flags.irq && state_q == ST_FLUSH ##1 (!$past(take) || dec_q.op == no_operation_op))
		else $error("interrupt return wrong");
	ret_literal_a: assert property (acc && w[15:8] == HB_RETL |=>
		dec_q.literal == dec_q.word[7:0] && dec_q.flags == 8'h00 && state_q == ST_FLUSH)
		else $error("literal return wrong");
	bank_load_a: assert property (acc && w[15:4] == 12'h010 |=>
		dec_q.op == bank_select_load_op && dec_q.literal[7:4] == 4'h0)
		else $error("bank select load wrong");
	port_pins_a: assert property (acc && w[15:12] == NIB_BIT_SET && port_hit |=>
		dec_q.read_pins)
		else $error("port modify missed live pins");
	presc_clr_a: assert property (acc && w[15:12] == NIB_BIT_TGL |=>
		dec_q.presc_clr == $past(w[8:0] == {1'b0, TMRZ_ADDR} && presc_assigned))
		else $error("prescaler clear wrong");

	skip_taken_c: cover property (acc && w[15:12] == NIB_SKIP_SET && file_bit);
	call_pair_c: cover property (acc && w[15:9] == 7'b1110110 ##1 take);
	table_rd_c: cover property (acc && w[15:2] == {HB_FIXED, LB_TRD});
	pointer_c: cover property (dec_valid_q && dec_q.op == pointer_load_op);

endmodule : mcubd_core

// File: tb/mcubd_tb.sv
`timescale 1ns/1ps
`define CK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
	import mcubd_pkg::*;
	typedef struct {
		mcubd_op_t   op;
		int          k;
		logic [20:0] v;
		logic [1:0]  c;
		logic [7:0]  f;
		logic [1:0]  x;
	} mcubd_note_t;
	logic         pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic         fetch_valid, file_bit, presc_assigned, dec_valid_q, er, t, p;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd, r;
	logic [15:0]  fetch_word;
	logic [19:0]  pc_inc, tg;
	mcubd_alu_t   alu_flags;
	mcubd_dec_t   dec_q;
	logic [31:0]  lf = 32'd66566;
	int           err_total, compares;
	mcubd_note_t  q[$], n;
	mcubd_op_t    lop [8] = '{literal_add_op, literal_subtract_op, literal_multiply_op,
		literal_and_op, literal_or_op, literal_xor_op, literal_move_op, literal_return_op};
	logic [7:0]   lhb [8] = '{8'h0f, 8'h08, 8'h0d, 8'h0b, 8'h09, 8'h0a, 8'h0e, 8'h0c};
	logic [7:0]   lfl [8] = '{8'hf8, 8'hf8, 8'h00, 8'h28, 8'h28, 8'h28, 8'h00, 8'h00};
	logic [15:0]  fxw [7] = '{16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
		16'h0000, 16'h00ff};
	mcubd_op_t    fxo [7] = '{standby_op, watchdog_clear_op, push_op, pop_op,
		decimal_adjust_op, no_operation_op, soft_reset_op};
	logic [7:0]   fxf [7] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h80, 8'h00, 8'hff};
	logic [3:0]   bno [3] = '{4'h9, 4'h8, 4'h7};
	mcubd_op_t    bop [3] = '{bit_clear_op, bit_set_op, bit_toggle_op};
	int           bix [4] = '{2, 3, 1, 0};

	mcubd_core dut_u (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .pc_inc(pc_inc), .alu_flags(alu_flags),
		.file_bit(file_bit), .presc_assigned(presc_assigned), .dec_q(dec_q),
		.dec_valid_q(dec_valid_q)
	);

	always #25 pclk = ~pclk;

	// ========================================
	// drivers
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction : rnd

	task automatic fetch(input logic [15:0] w);
		fetch_valid <= 1'b1;
		fetch_word <= w;
		pc_inc <= pc_inc + 20'h1;
		@(posedge pclk);
	endtask : fetch

	task automatic wd(input logic [15:0] w, input mcubd_op_t o, input int k,
		input logic [20:0] v, input logic [1:0] c, input logic [7:0] f, input logic [1:0] x);
		q.push_back('{o, k, v, c, f, x});
		fetch(w);
	endtask : wd

	task automatic nop(input logic [15:0] w);
		wd(w, no_operation_op, 0, 21'h0, 2'd1, 8'h00, 2'b00);
	endtask : nop

	task automatic idle(input int m);
		fetch_valid <= 1'b0;
		repeat (m) @(posedge pclk);
	endtask : idle

	// waits on pready with no assumed latency; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// ========================================
	// monitor: sampled on the falling edge so registered outputs have settled
	always @(negedge pclk) begin
		if (dec_valid_q === 1'b1) begin
			if (q.size() == 0) begin
				`CK(1'b1, 1'b0)
			end else begin
				n = q.pop_front();
				`CK(dec_q.op, n.op)
				`CK(dec_q.cycles, n.c)
				`CK(dec_q.flags, n.f)
				`CK({dec_q.read_pins, dec_q.presc_clr}, n.x)
				case (n.k)
				1: `CK(dec_q.literal, n.v[7:0])
				2: `CK({dec_q.taken, dec_q.target}, n.v)
				3: `CK({dec_q.bit_num, dec_q.bank_a, dec_q.file_addr}, n.v[11:0])
				4: `CK({dec_q.ptr_sel, dec_q.ptr_val}, n.v[13:0])
				5: `CK(dec_q.tbl_mode, n.v[1:0])
				6: `CK(dec_q.fast, n.v[0])
				7: `CK({dec_q.fast, dec_q.target}, n.v)
				default: ;
				endcase
			end
		end
	end

	// a full run is under two hundred cycles, so 2000 cycles means a hang
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	// ========================================
	// tests
	initial begin
		pclk = 1'b0;
		ce = 1'b1;
		{presetn, psel, penable, pwrite, paddr, pwdata, fetch_valid} = '0;
		{fetch_word, pc_inc, alu_flags, file_bit, presc_assigned} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CK({dec_valid_q, dec_q}, '0)
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			wd({lhb[i], r[7:0]}, lop[i], 1, {13'h0, r[7:0]}, (i == 7) ? 2'd2 : 2'd1, lfl[i],
				2'b00);
			if (i == 7) nop(16'h0e5a);
		end
		wd(16'h0109, bank_select_load_op, 1, 21'h9, 2'd1, 8'h00, 2'b00);
		done("literal");
		for (int i = 0; i < 7; i++) wd(fxw[i], fxo[i], 0, 21'h0, 2'd1, fxf[i], 2'b00);
		for (int s = 0; s < 2; s++) begin
			wd({15'h0008, s[0]}, interrupt_return_op, 6, {20'h0, s[0]}, 2'd2, 8'h02, 2'b00);
			nop(16'h0e00);
			wd({15'h0009, s[0]}, return_op, 6, {20'h0, s[0]}, 2'd2, 8'h00, 2'b00);
			nop(16'h0e00);
		end
		for (int i = 8; i < 16; i++) begin
			wd({12'h000, 4'(i)}, (i < 12) ? table_read_op : table_write_op, 5, 21'(i & 3),
				2'd2, 8'h00, 2'b00);
			nop(16'h0e00);
		end
		done("fixed");
		for (int j = 0; j < 3; j++) for (int m = 0; m < 4; m++) begin
			r = rnd();
			case (m)
			1: r[8:0] = {6'h10, r[2:0]};
			2: r[8:0] = 9'h0d0;
			3: r[8:0] = 9'h1d0;
			default: ;
			endcase
			p = (m == 2) | r[12];
			presc_assigned <= p;
			wd({bno[j], r[11:0]}, bop[j], 3, {9'h0, r[11:0]}, 2'd1, 8'h00,
				{r[8:3] == 6'h10, r[8:0] == 9'h0d0 && p});
		end
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			file_bit <= i[0];
			t = i[1] ^ i[0];
			wd({3'b101, i[1], r[11:0]}, i[1] ? skip_if_bit_clear_op : skip_if_bit_set_op, 3,
				{9'h0, r[11:0]}, t ? 2'd2 : 2'd1, 8'h00, 2'b00);
			if (t) begin
				nop(16'hec12);
				nop(16'hf345);
			end
		end
		done("bit");
		for (int c = 0; c < 8; c++) begin
			r = rnd();
			alu_flags <= r[3:0];
			t = r[bix[c >> 1]] ^ c[0];
			tg = pc_inc + 20'h1 + {{12{r[15]}}, r[15:8]};
			wd({5'b11100, 3'(c), r[15:8]}, cond_branch_op, 2, {t, tg},
				t ? 2'd2 : 2'd1, 8'h00, 2'b00);
			if (t) nop(16'h0e00);
		end
		done("branch");
		r = rnd();
		for (int s = 0; s < 2; s++) begin
			fetch({7'b1110110, s[0], r[7:0]});
			wd({4'hf, r[19:8]}, call_op, 7, {s[0], r[19:0]}, 2'd2, 8'h00, 2'b00);
		end
		fetch({8'hef, r[7:0]});
		wd({4'hf, r[19:8]}, goto_op, 2, {1'b0, r[19:0]}, 2'd2, 8'h00, 2'b00);
		fetch({8'hee, 2'b00, r[21:20], r[27:24]});
		wd({8'hf0, r[7:0]}, pointer_load_op, 4, {7'h0, r[21:20], r[27:24], r[7:0]}, 2'd2,
			8'h00, 2'b00);
		nop(16'hfabc);
		fetch(16'hec34);
		presetn <= 1'b0;
		fetch_valid <= 1'b0;
		repeat (2) @(posedge pclk);
		`CK(dec_valid_q, 1'b0)
		presetn <= 1'b1;
		@(posedge pclk);
		nop(16'hf111);
		done("two_word");
		idle(1);
		apb(1'b0, REG_CTRL, 32'h0);
		`CK(rd[0], CTRL_RST)
		apb(1'b1, REG_CTRL, 32'h0);
		nop(16'h0e77);
		nop(16'h0008);
		idle(1);
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_COUNT, 32'h0);
		for (int k = 0; k < 3; k++) wd({8'h0e, 8'(k)}, literal_move_op, 1, 21'(k), 2'd1, 8'h00,
			2'b00);
		idle(2);
		apb(1'b0, REG_COUNT, 32'h0);
		`CK(rd, 32'h3)
		apb(1'b0, REG_LAST, 32'h0);
		`CK(rd[15:0], 16'h0e02)
		apb(1'b0, REG_STATUS, 32'h0);
		`CK({rd[12:10], rd[4:0]}, {3'b001, 5'(literal_move_op)})
		apb(1'b0, 12'h010, 32'h0);
		`CK({er, rd}, 33'h100000000)
		done("apb");
		// frozen clock enable: the word must be taken once, only after ce returns
		q.push_back('{literal_move_op, 1, 21'h99, 2'd1, 8'h00, 2'b00});
		ce <= 1'b0;
		fetch(16'h0e99);
		repeat (2) @(posedge pclk);
		ce <= 1'b1;
		@(posedge pclk);
		idle(3);
		`CK(q.size(), 0)
		done("enable");
		wrap_up();
	end
endmodule : tb
